// [cscl_pkg.sv]
// Shared constants and types for the crosspoint serial configuration link.
// Assumes a 100 MHz system clock on both ends.
package cscl_pkg;

  // Switch matrix geometry
  localparam int SW_ROWS = 16;
  localparam int SW_COLS = 16;
  localparam int SW_BITS = SW_ROWS * SW_COLS;

  // System clock rate
  localparam int CLK_MHZ = 100;

  // Link timing, figures in their own units
  localparam int T_SCLK_HIGH_NS = 100;
  localparam int T_SCLK_LOW_NS = 100;
  localparam int T_STROBE_DLY_NS = 65;
  localparam int T_STROBE_W_NS = 65;
  localparam int T_HOLD_MAX_MS = 5;
  localparam int F_SCLK_MIN_KHZ = 20;

  // Least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int SCLK_HIGH_CYC = ns_to_cyc(T_SCLK_HIGH_NS);
  localparam int SCLK_LOW_CYC = ns_to_cyc(T_SCLK_LOW_NS);
  localparam int STROBE_DLY_CYC = ns_to_cyc(T_STROBE_DLY_NS);
  localparam int STROBE_W_CYC = ns_to_cyc(T_STROBE_W_NS);
  // Longest times round down
  localparam int HOLD_MAX_CYC = T_HOLD_MAX_MS * 1000 * CLK_MHZ;
  localparam int SCLK_GAP_CYC = CLK_MHZ * 1000 / F_SCLK_MIN_KHZ;

  // Controller sequencer
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_GAP,
    ST_STROBE
  } cscl_ctrl_state_t;

endpackage

// [cscl_link_if.sv]
// Serial configuration link between the controller and the crosspoint end.
// Assumes the controller drives clock, data and strobe; the device drives data out.
`timescale 1ns/1ps
interface cscl_link_if;
  logic shift_clk;
  logic serial_config_in;
  logic latch_strobe_b;
  logic serial_config_out;

  modport dev (
    input shift_clk,
    input serial_config_in,
    input latch_strobe_b,
    output serial_config_out
  );

  modport ctrl (
    output shift_clk,
    output serial_config_in,
    output latch_strobe_b,
    input serial_config_out
  );
endinterface

// [cscl_dev.sv]
// Crosspoint end: 256-bit shift register on the link clock, static latches on i_clk.
// Assumes the shift clock is quiet while the strobe is low and around reset.
//
// What this block and the controller do
// R1: Each shift clock rise shifts serial input in
// R2: Exactly 256 shift bits feeding 256 latches
// R3: First bit shifted is row 15 column 15
// R4: Controller shifts all bits, then pulses strobe
// R5: Strobe low copies shift register into latches
// R6: Serial output is the 256th stage
// R7: Serial output is not inverted
// R8: Controller keeps shift clock at least 20 kHz
// R9: Strobe pulse within 5 ms of last bit
// R10: Latches hold regardless of shift clock
// R11: Devices chain output to next input
// R12: Latched one closes switch, zero opens
`timescale 1ns/1ps
module cscl_dev
  import cscl_pkg::*;
#(
  parameter int HOLD_CYC = cscl_pkg::HOLD_MAX_CYC,
  parameter int GAP_CYC = cscl_pkg::SCLK_GAP_CYC
)(
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Serial link
  cscl_link_if.dev lk,
  // Switch matrix control, bit row*16+col
  output logic [cscl_pkg::SW_BITS-1:0] o_switch_closed,
  output logic [cscl_pkg::SW_ROWS-1:0] o_row_any,
  output logic o_config_valid,
  // Load status
  output logic o_commit,
  output logic o_short_load,
  output logic o_clock_slow,
  output logic o_hold_expired
);
  import cscl_pkg::*;

  // Counter widths follow the load size and the hold limit
  localparam int CW = $clog2(SW_BITS + 1);
  localparam int GW = $clog2(HOLD_CYC + 1);

  // Fewer than one full load shifted since the last commit
  function automatic logic below_full(input logic [CW-1:0] n);
    return (n < CW'(SW_BITS));
  endfunction

  // Link clock domain
  typedef struct packed {
    logic [SW_BITS-1:0] sr;
    logic shift_tog;
  } cscl_dev_link_t;

  // System clock domain
  typedef struct packed {
    logic act_s1;
    logic act_s2;
    logic act_s3;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic [SW_BITS-1:0] latch;
    logic [SW_ROWS-1:0] row_any;
    logic valid;
    logic commit;
    logic [CW-1:0] shifts;
    logic [GW-1:0] idle;
    logic clock_slow;
    logic hold_expired;
    logic short_load;
  } cscl_dev_core_t;

  cscl_dev_link_t l;
  cscl_dev_link_t next_l;
  cscl_dev_core_t c;
  cscl_dev_core_t next_c;

  logic shift_evt;
  logic strobe_low;
  logic strobe_fall;
  logic pending;

  // Shift register, advanced on every link clock rise
  always_comb
  begin
    next_l = l;
    next_l.sr = {l.sr[SW_BITS-2:0], lk.serial_config_in}; // [R1] [R2] [R3]
    next_l.shift_tog = ~l.shift_tog;
  end

  // Shares the system reset; the shift clock must be still at release
  always_ff @(posedge lk.shift_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      l <= '0;
    end
    else
    begin
      l <= next_l;
    end
  end

  // Last stage drives the chain output, same polarity
  assign lk.serial_config_out = l.sr[SW_BITS-1]; // [R6] [R7] [R11]

  // Events seen in the system domain
  // One toggle per shift, so no shift is lost however slow the link
  assign shift_evt = c.tog_s2 ^ c.tog_s3;
  assign strobe_low = c.act_s2;
  assign strobe_fall = c.act_s2 & ~c.act_s3;
  assign pending = (c.shifts != '0);

  always_comb
  begin
    next_c = c;
    // Two-flop synchronisers for strobe and shift toggle
    next_c.act_s1 = ~lk.latch_strobe_b;
    next_c.act_s2 = c.act_s1;
    next_c.act_s3 = c.act_s2;
    next_c.tog_s1 = l.shift_tog;
    next_c.tog_s2 = c.tog_s1;
    next_c.tog_s3 = c.tog_s2;
    next_c.commit = strobe_fall;

    // Shift register is frozen while the strobe is low, so the
    // wide word is quasi-static when it is copied across
    if (strobe_low)
    begin
      next_c.latch = l.sr; // [R5] [R4]
      next_c.valid = 1'b1;
    end
    else
    begin
      // Static latches ignore the shift clock entirely
      next_c.latch = c.latch; // [R10]
    end

    for (int r = 0; r < SW_ROWS; r++)
    begin
      next_c.row_any[r] = |next_c.latch[r*SW_COLS +: SW_COLS]; // [R12]
    end

    // Shifts since the last commit, saturating at one full load
    if (strobe_fall)
    begin
      next_c.short_load = below_full(c.shifts); // [R4]
      next_c.shifts = '0;
    end
    else if (shift_evt && below_full(c.shifts))
    begin
      next_c.shifts = c.shifts + 1'b1;
    end

    // Cycles since the last shift, saturating at the hold limit
    if (shift_evt)
    begin
      next_c.idle = '0;
    end
    else if (c.idle < GW'(HOLD_CYC))
    begin
      next_c.idle = c.idle + 1'b1;
    end

    // Stall in mid-load: shift clock below its least rate
    if (strobe_fall)
    begin
      next_c.clock_slow = 1'b0;
    end
    if (pending && below_full(c.shifts) && (c.idle == GW'(GAP_CYC)))
    begin
      next_c.clock_slow = 1'b1; // [R8]
    end

    // Loaded data left waiting too long for its strobe
    // An expiry on the commit cycle itself stays set
    if (strobe_fall)
    begin
      next_c.hold_expired = 1'b0;
    end
    if (pending && (c.idle == GW'(HOLD_CYC)))
    begin
      next_c.hold_expired = 1'b1; // [R9]
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      c <= '0;
    end
    else
    begin
      c <= next_c;
    end
  end

  // All switches open until the first commit
  assign o_switch_closed = c.latch; // [R12]
  assign o_row_any = c.row_any;
  assign o_config_valid = c.valid;
  assign o_commit = c.commit;
  assign o_short_load = c.short_load;
  assign o_clock_slow = c.clock_slow;
  assign o_hold_expired = c.hold_expired;
endmodule

// [cscl_ctrl.sv]
// Controller end: makes the shift clock by division, shifts a chain, strobes.
// Assumes one or more crosspoint ends chained on the link.
`timescale 1ns/1ps
module cscl_ctrl
  import cscl_pkg::*;
#(
  parameter int N_DEV = 1
)(
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Load request, bit d*256+row*16+col; first device in chain (nearest the controller) is d=0
  input wire logic i_start,
  input wire logic [N_DEV*cscl_pkg::SW_BITS-1:0] i_config,
  output logic o_busy,
  output logic o_done,
  // Previous chain contents, same layout
  output logic [N_DEV*cscl_pkg::SW_BITS-1:0] o_readback,
  // Serial link
  cscl_link_if.ctrl lk
);
  import cscl_pkg::*;

  localparam int NB = N_DEV * SW_BITS;
  localparam int BW = $clog2(NB + 1);
  localparam int DW = 8;

  typedef struct packed {
    cscl_ctrl_state_t state;
    logic [DW-1:0] div;
    logic [BW-1:0] bits;
    logic [NB-1:0] data;
    logic [NB-1:0] rb;
    logic sclk;
    logic sdata;
    logic strobe_b;
    logic serial_config_out_s1;
    logic serial_config_out_s2;
    logic done;
  } cscl_ctrl_st_t;

  cscl_ctrl_st_t s;
  cscl_ctrl_st_t next_s;
  logic div_end;

  always_comb
  begin
    case (s.state)
      ST_LOW: div_end = (s.div == DW'(SCLK_LOW_CYC - 1));
      ST_HIGH: div_end = (s.div == DW'(SCLK_HIGH_CYC - 1));
      ST_GAP: div_end = (s.div == DW'(STROBE_DLY_CYC - 1));
      ST_STROBE: div_end = (s.div == DW'(STROBE_W_CYC - 1));
      default: div_end = 1'b0;
    endcase
  end

  always_comb
  begin
    next_s = s;
    next_s.serial_config_out_s1 = lk.serial_config_out;
    next_s.serial_config_out_s2 = s.serial_config_out_s1;
    next_s.done = 1'b0;
    next_s.div = div_end ? '0 : s.div + 1'b1;
    case (s.state)
      ST_IDLE:
      begin
        next_s.div = '0;
        if (i_start)
        begin
          next_s.data = i_config;
          next_s.sdata = i_config[NB-1]; // [R3]
          next_s.bits = '0;
          next_s.state = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (div_end)
        begin
          next_s.sclk = 1'b1; // [R1]
          next_s.rb = {s.rb[NB-2:0], s.serial_config_out_s2}; // [R11]
          next_s.state = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (div_end)
        begin
          // Data moves on the fall: hold and setup both a half period
          next_s.sclk = 1'b0;
          next_s.bits = s.bits + 1'b1;
          next_s.data = {s.data[NB-2:0], 1'b0};
          next_s.sdata = s.data[NB-2]; // [R3]
          // Clock runs far above its least rate while loading [R8]
          next_s.state = (s.bits == BW'(NB - 1)) ? ST_GAP : ST_LOW; // [R4]
        end
      end
      ST_GAP:
      begin
        if (div_end)
        begin
          next_s.strobe_b = 1'b0; // [R4] [R9]
          next_s.state = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (div_end)
        begin
          next_s.strobe_b = 1'b1; // [R9]
          next_s.done = 1'b1;
          next_s.state = ST_IDLE;
        end
      end
      default:
      begin
        next_s.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      s <= '0;
      s.strobe_b <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign lk.shift_clk = s.sclk;
  assign lk.serial_config_in = s.sdata;
  assign lk.latch_strobe_b = s.strobe_b;
  assign o_busy = (s.state != ST_IDLE);
  assign o_done = s.done;
  assign o_readback = s.rb;
endmodule

// [cscl_link_asserts.sv]
// Link checker: order and timing of the serial configuration link.
// Assumes the link is sampled on the controller's system clock.
`timescale 1ns/1ps
module cscl_link_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Link
  input wire logic shift_clk,
  input wire logic serial_config_in,
  input wire logic latch_strobe_b,
  input wire logic serial_config_out
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_strobe_clk_low: assert property (
    !latch_strobe_b |-> !shift_clk)
    else $error("strobe with clock high");
  a_strobe_delay: assert property (
    $fell(latch_strobe_b) |-> !$past(shift_clk, 7))
    else $error("strobe too early");
  a_strobe_width: assert property (
    $fell(latch_strobe_b) |-> !latch_strobe_b[*7] ##1 latch_strobe_b)
    else $error("strobe width");
  a_strobe_quiet: assert property (
    $rose(latch_strobe_b) |-> (latch_strobe_b && !shift_clk)[*8])
    else $error("shift right after strobe");
  a_clk_high_width: assert property (
    $rose(shift_clk) |=> $stable(shift_clk)[*8] ##1 shift_clk ##1 !shift_clk)
    else $error("clock high phase");
  a_clk_next_rise: assert property (
    $fell(shift_clk) |-> ##[1:10] ($rose(shift_clk) || $fell(latch_strobe_b)))
    else $error("clock or strobe late");
  a_data_hold: assert property (
    shift_clk |-> $stable(serial_config_in))
    else $error("data moved with clock high");
  a_out_on_shift: assert property (
    $changed(serial_config_out) |-> shift_clk)
    else $error("output moved without shift");

  cover property ($fell(latch_strobe_b));
  cover property ($rose(serial_config_out));
  cover property ($rose(shift_clk) && serial_config_in);
endmodule

// [cscl_tb.sv]
// Bench: controller and one end joined, plus a second end driven by hand.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ps
module cscl_tb;
  import cscl_pkg::*;
  localparam logic [SW_BITS-1:0] A = {8'h80, 240'h0, 8'h03};
  logic i_clk, i_rst_b, i_start, done, valid, short_ld, slow2, hold2, short2, busy, commit2;
  logic [SW_BITS-1:0] cfg, sw, sw2, rb;
  logic [SW_ROWS-1:0] row_any;
  int mismatches, n_compared, cyc;
  cscl_link_if lk();
  cscl_link_if lk2();
  cscl_ctrl i_cscl_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
    .i_config(cfg), .o_busy(busy), .o_done(done), .o_readback(rb), .lk(lk));
  cscl_dev #(.HOLD_CYC(400), .GAP_CYC(100)) i_cscl_dev (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .lk(lk), .o_switch_closed(sw), .o_row_any(row_any), .o_config_valid(valid),
    .o_commit(), .o_short_load(short_ld), .o_clock_slow(), .o_hold_expired());
  cscl_dev #(.HOLD_CYC(400), .GAP_CYC(100)) i_cscl_dev_b (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .lk(lk2), .o_switch_closed(sw2), .o_row_any(), .o_config_valid(), .o_commit(commit2),
    .o_short_load(short2), .o_clock_slow(slow2), .o_hold_expired(hold2));
  cscl_link_asserts i_cscl_link_asserts (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .shift_clk(lk.shift_clk), .serial_config_in(lk.serial_config_in),
    .latch_strobe_b(lk.latch_strobe_b), .serial_config_out(lk.serial_config_out));

  initial
  begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      test_done();
    end
  end

  task automatic test_done;
    if (mismatches == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk_word(input logic [SW_BITS-1:0] got, input logic [SW_BITS-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t word %h", $time, got);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t bit %b", $time, got);
    end
  endtask

  // Full load; latches must keep the old word while shifting
  task automatic load(input logic [SW_BITS-1:0] c, input logic [SW_BITS-1:0] old);
    int n;
    @(negedge i_clk);
    cfg = c;
    i_start = 1;
    @(negedge i_clk);
    i_start = 0;
    chk_bit(busy, 1'b1);
    @(posedge lk.shift_clk);
    #1 chk_bit(lk.serial_config_in, c[SW_BITS-1]);
    repeat (100) @(posedge lk.shift_clk);
    #1 chk_word(sw, old);
    n = 0;
    while (done !== 1'b1 && n < 6000)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_bit(done, 1'b1);
    repeat (3) @(negedge i_clk);
    chk_bit(busy, 1'b0);
  endtask

  task automatic t_two_loads;
    load(A, '0);
    chk_word(sw, A);
    chk_word({240'h0, row_any}, 256'h8001);
    chk_bit(valid, 1'b1);
    chk_bit(short_ld, 1'b0);
    load(~A, A);
    chk_word(rb, A);
    chk_word(sw, ~A);
  endtask

  // Link clock of 48 ns made here, only within the frame
  task automatic shift2(input logic b);
    lk2.serial_config_in = b;
    #24 lk2.shift_clk = 1;
    #24 lk2.shift_clk = 0;
  endtask

  task automatic t_short_load;
    int n;
    shift2(1'b1);
    shift2(1'b0);
    shift2(1'b1);
    repeat (150) @(negedge i_clk);
    chk_bit(slow2, 1'b1);
    chk_bit(hold2, 1'b0);
    repeat (300) @(negedge i_clk);
    chk_bit(hold2, 1'b1);
    lk2.latch_strobe_b = 1'b0;
    n = 0;
    while (commit2 !== 1'b1 && n < 10)
    begin
      @(negedge i_clk);
      n++;
    end
    chk_bit(commit2, 1'b1);
    repeat (7) @(negedge i_clk);
    lk2.latch_strobe_b = 1'b1;
    repeat (10) @(negedge i_clk);
    chk_bit(short2, 1'b1);
    chk_word(sw2, 256'h5);
    chk_bit(slow2, 1'b0);
  endtask

  initial
  begin
    i_rst_b = 1'b1;
    i_start = 0;
    cfg = '0;
    lk2.shift_clk = 0;
    lk2.serial_config_in = 0;
    lk2.latch_strobe_b = 1;
    // A true falling edge, so the link-clocked flops reset too
    #1 i_rst_b = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_b = 1;
    chk_word(sw, '0);
    t_two_loads();
    t_short_load();
    test_done();
  end
endmodule
